//--- hw/pieb_pkg.sv
// pieb_pkg: register map, field positions and carrier types of the
// peripheral interrupt enable bank.
// assumes: included before the bank, used only as pieb_pkg::name.
package pieb_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] PIEB_OFS_ENABLE = 8'h8c;
   localparam logic [7:0] PIEB_OFS_STATUS = 8'h8d;
   localparam logic [7:0] PIEB_OFS_MASK   = 8'h8e;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int PIEB_BIT_MEM_WRITE_DONE = 7;
   localparam int PIEB_BIT_COMPARATOR     = 6;
   localparam int PIEB_BIT_SERIAL_RX      = 5;
   localparam int PIEB_BIT_SERIAL_TX      = 4;
   localparam int PIEB_BIT_UNUSED         = 3;
   localparam int PIEB_BIT_CAPCOMP        = 2;
   localparam int PIEB_BIT_PERIOD_MATCH   = 1;
   localparam int PIEB_BIT_OVERFLOW       = 0;

   // -----------------------------------------------------------------
   // reset values and implemented bits
   // -----------------------------------------------------------------
   localparam logic [7:0] PIEB_RST_ENABLE = 8'h00;
   localparam logic [7:0] PIEB_RST_STATUS = 8'h00;
   localparam logic [7:0] PIEB_RST_MASK   = 8'h00;
   localparam logic [7:0] PIEB_RST_DATA   = 8'h00;
   localparam logic [7:0] PIEB_IMPL_BITS  = 8'hf7;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pieb_bus_req_s;

   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] status;
      logic [7:0] mask;
      logic [7:0] flag_prev;
      logic [7:0] rdata;
   } pieb_state_s;

endpackage

//--- hw/pieb_bank.sv
// pieb_bank: peripheral interrupt enable register, per-source request
// gating, sticky event status with mask and two interrupt lines (periph_irq_req, event_irq).
// assumes: flags and strobes come from logic on clk_sys; the flag
// register itself and the peripherals live outside.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

module pieb_bank (
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   input  wire logic                  clk_en,
   input  wire pieb_pkg::pieb_bus_req_s bus_req,
   output logic [7:0]                 bus_rdata,
   input  wire logic                  mem_write_done_flag,
   input  wire logic                  comparator_change_flag,
   input  wire logic                  rx_buf_full,
   input  wire logic                  serial_tx_flag,
   input  wire logic                  capcomp_flag,
   input  wire logic                  period_match_flag,
   input  wire logic                  overflow_timer_flag,
   input  wire logic                  global_irq_en,
   input  wire logic                  periph_irq_en,
   output logic [7:0]                 src_irq_req,
   output logic                       periph_irq_req,
   output logic                       event_irq
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   pieb_pkg::pieb_state_s st_r;
   pieb_pkg::pieb_state_s st_nxt;
   logic [7:0]            flags;
   logic [7:0]            rise;
   logic [7:0]            w1c;
   logic                  serial_rx_flag;

   // -----------------------------------------------------------------
   // flag gathering
   // -----------------------------------------------------------------
   assign serial_rx_flag = rx_buf_full;

   always_comb begin
      flags = 8'h00;
      flags[pieb_pkg::PIEB_BIT_MEM_WRITE_DONE] = mem_write_done_flag;
      flags[pieb_pkg::PIEB_BIT_COMPARATOR]     = comparator_change_flag;
      flags[pieb_pkg::PIEB_BIT_SERIAL_RX]      = serial_rx_flag;
      flags[pieb_pkg::PIEB_BIT_SERIAL_TX]      = serial_tx_flag;
      flags[pieb_pkg::PIEB_BIT_CAPCOMP]        = capcomp_flag;
      flags[pieb_pkg::PIEB_BIT_PERIOD_MATCH]   = period_match_flag;
      flags[pieb_pkg::PIEB_BIT_OVERFLOW]       = overflow_timer_flag;
   end

   // -----------------------------------------------------------------
   // request gating
   // -----------------------------------------------------------------
   // each source request is flag and enable; bit 3 enable is always zero
   assign src_irq_req    = flags & st_r.enable;
   assign periph_irq_req = global_irq_en & periph_irq_en & (|src_irq_req);
   assign event_irq      = |(st_r.status & st_r.mask);
   assign bus_rdata      = st_r.rdata;

   // events are taken from flag edges whatever the enables hold
   assign rise = flags & ~st_r.flag_prev & pieb_pkg::PIEB_IMPL_BITS;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      w1c    = 8'h00;
      st_nxt.flag_prev = flags;
      st_nxt.rdata     = pieb_pkg::PIEB_RST_DATA;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            pieb_pkg::PIEB_OFS_ENABLE: begin
               st_nxt.enable = bus_req.wdata & pieb_pkg::PIEB_IMPL_BITS;
            end
            pieb_pkg::PIEB_OFS_STATUS: begin
               w1c = bus_req.wdata;
            end
            pieb_pkg::PIEB_OFS_MASK: begin
               st_nxt.mask = bus_req.wdata & pieb_pkg::PIEB_IMPL_BITS;
            end
            default: begin
               st_nxt.enable = st_r.enable;
            end
         endcase
      end
      // set wins over a clear in the same cycle
      st_nxt.status = ((st_r.status & ~w1c) | rise) & pieb_pkg::PIEB_IMPL_BITS;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            pieb_pkg::PIEB_OFS_ENABLE: begin
               st_nxt.rdata = st_r.enable & pieb_pkg::PIEB_IMPL_BITS;
            end
            pieb_pkg::PIEB_OFS_STATUS: begin
               st_nxt.rdata = st_r.status;
            end
            pieb_pkg::PIEB_OFS_MASK: begin
               st_nxt.rdata = st_r.mask;
            end
            default: begin
               st_nxt.rdata = pieb_pkg::PIEB_RST_DATA;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r.enable    <= pieb_pkg::PIEB_RST_ENABLE;
         st_r.status    <= pieb_pkg::PIEB_RST_STATUS;
         st_r.mask      <= pieb_pkg::PIEB_RST_MASK;
         st_r.flag_prev <= pieb_pkg::PIEB_RST_DATA;
         st_r.rdata     <= pieb_pkg::PIEB_RST_DATA;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

endmodule

//--- verif/pieb_props.sv
// pieb_props: request gating checks on the bank ports
// assumes: bound into pieb_bank, one clock domain
`timescale 1ns/1ps
module pieb_props (
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       mem_write_done_flag,
   input wire logic       comparator_change_flag,
   input wire logic       rx_buf_full,
   input wire logic       serial_tx_flag,
   input wire logic       capcomp_flag,
   input wire logic       period_match_flag,
   input wire logic       overflow_timer_flag,
   input wire logic       global_irq_en,
   input wire logic       periph_irq_en,
   input wire logic       periph_irq_req,
   input wire logic [7:0] src_irq_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   AST_B7: assert property (src_irq_req[7] |-> mem_write_done_flag) else $error("b7 req");
   AST_B4: assert property (src_irq_req[4] |-> serial_tx_flag) else $error("b4 req");
   AST_B2: assert property (src_irq_req[2] |-> capcomp_flag) else $error("b2 req");
   AST_B1: assert property (src_irq_req[1] |-> period_match_flag) else $error("b1 req");
   AST_B0: assert property (src_irq_req[0] |-> overflow_timer_flag) else $error("b0 req");
   AST_B3: assert property (!src_irq_req[3]) else $error("b3 req");
   AST_B6: assert property (src_irq_req[6] |-> comparator_change_flag) else $error("b6 req");
   AST_B5: assert property (src_irq_req[5] |-> rx_buf_full) else $error("b5 req");
   AST_PIRQ: assert property (periph_irq_req == (global_irq_en & periph_irq_en & (|src_irq_req))) else $error("periph req");
endmodule
bind pieb_bank pieb_props u_props (.*);

//--- verif/tb.sv
// tb: self-checking bench of the bank over its register port
// assumes: pieb_pkg and pieb_bank compiled first, 200 MHz clock
`timescale 1ns/1ps
module tb;
   logic                    clk_sys = 0, reset_n = 0, pirq, eirq;
   logic [7:0]              rdata, src, d, en;
   logic [6:0]              fl = '0;
   logic                    gen = 1'b1, pen = 1'b1, ce = 1'b1;
   pieb_pkg::pieb_bus_req_s req = '0;
   int                      miscompares = 0, cmp_count = 0;
   initial forever #2.5 clk_sys = ~clk_sys;
   pieb_bank u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(ce), .bus_req(req),
      .bus_rdata(rdata), .mem_write_done_flag(fl[6]), .comparator_change_flag(fl[5]),
      .rx_buf_full(fl[4]), .serial_tx_flag(fl[3]), .capcomp_flag(fl[2]),
      .period_match_flag(fl[1]), .overflow_timer_flag(fl[0]), .global_irq_en(gen),
      .periph_irq_en(pen), .src_irq_req(src), .periph_irq_req(pirq), .event_irq(eirq));
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      cmp_count++;
      miscompares += (s !== e);
      if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(posedge clk_sys) req <= '{a, v, 1'b1, 1'b0};
      @(posedge clk_sys) req.wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk_sys) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys) req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #20000 miscompares++;
      give_verdict;
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(pieb_pkg::PIEB_OFS_ENABLE);
      chk("enable_rst", d, pieb_pkg::PIEB_RST_ENABLE);
      // flags rise with every enable clear
      repeat (2) @(posedge clk_sys) fl <= 7'h7f;
      rd(pieb_pkg::PIEB_OFS_STATUS);
      chk("status", d, 8'hf7);
      chk("irq_masked", {7'h00, eirq}, 8'h00);
      wr(pieb_pkg::PIEB_OFS_MASK, 8'hff);
      #1 chk("irq_unmasked", {7'h00, eirq}, 8'h01);
      wr(pieb_pkg::PIEB_OFS_STATUS, 8'hf7);
      #1 chk("irq_cleared", {7'h00, eirq}, 8'h00);
      // one enable bit at a time, all flags high
      for (int i = 0; i < 8; i++) begin
         en = 8'h01 << i;
         wr(pieb_pkg::PIEB_OFS_ENABLE, en);
         #1 chk("src_req", src, en & 8'hf7);
         rd(pieb_pkg::PIEB_OFS_ENABLE);
         chk("enable_rd", d, en & 8'hf7);
      end
      rd(8'h00);
      chk("unmapped", d, 8'h00);
      // global enable gates the combined request
      wr(pieb_pkg::PIEB_OFS_ENABLE, 8'hff);
      #1 chk("pirq_on", {7'h00, pirq}, 8'h01);
      @(posedge clk_sys) gen <= 1'b0;
      #1 chk("pirq_gated", {7'h00, pirq}, 8'h00);
      @(posedge clk_sys) begin
         gen <= 1'b1;
         fl  <= 7'h00;
      end
      #1 chk("src_low", src, 8'h00);
      // clock enable low freezes the bank
      @(posedge clk_sys) ce <= 1'b0;
      wr(pieb_pkg::PIEB_OFS_ENABLE, 8'h00);
      @(posedge clk_sys) ce <= 1'b1;
      rd(pieb_pkg::PIEB_OFS_ENABLE);
      chk("frozen", d, 8'hf7);
      give_verdict;
   end
endmodule
